/* File: core/aogc_top.v */
// Offset and gain correction datapath with its AXI4-Lite register file
// Contract
// - gain calibration converts selected pair, stores gain
// - input full scale is 16777216 codes
// - plain modes apply offset and gain always
// - 16-bit variant subtracts offset times 256
// - 20-bit variant subtracts offset times 64
// - 24-bit variant subtracts offset times 4
// - multiply by gain, divide by 0x1000000
// - overflow flag set outside range, else cleared
// - 16-bit clamps to -32768 / +32767
// - 20-bit clamps to -524288 / +524287
// - 24-bit clamps to -8388608 / +8388607
// - corrected value written to result register
// - chopped modes skip offset, keep gain, clamp
// - excitation sources swap with input polarity in modes 0x6 and 0x7 only
// - mode 0xD starts gain cal, then idle
// - gain update drives ready-low from 1 to 0
// - mode 0xC stores offset used by correction
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "aogc_regs.vh"

module aogc_top #(
	parameter FILT_W = 26,
	parameter OFS_W  = 24,
	parameter GAIN_W = 24
) (
	input  wire              i_clk,
	input  wire              i_reset,
	input  wire [7:0]        i_s_axi_awaddr,
	input  wire              i_s_axi_awvalid,
	output reg               o_s_axi_awready,
	input  wire [31:0]       i_s_axi_wdata,
	input  wire [3:0]        i_s_axi_wstrb,
	input  wire              i_s_axi_wvalid,
	output reg               o_s_axi_wready,
	output reg  [1:0]        o_s_axi_bresp,
	output reg               o_s_axi_bvalid,
	input  wire              i_s_axi_bready,
	input  wire [7:0]        i_s_axi_araddr,
	input  wire              i_s_axi_arvalid,
	output reg               o_s_axi_arready,
	output reg  [31:0]       o_s_axi_rdata,
	output reg  [1:0]        o_s_axi_rresp,
	output reg               o_s_axi_rvalid,
	input  wire              i_s_axi_rready,
	input  wire              i_filt_valid,
	input  wire [FILT_W-1:0] i_filt_data,
	input  wire              i_chop_phase,
	output reg  [3:0]        o_mode,
	output reg  [3:0]        o_positive_input_select,
	output reg  [3:0]        o_negative_input_select,
	output reg               o_internal_ref_sel,
	output reg               o_first_amp_stage_enable,
	output reg  [2:0]        o_second_amp_stage_gain,
	output reg  [3:0]        o_excitation_source_one_route,
	output reg  [3:0]        o_excitation_source_two_route,
	output reg               o_ready_low_status,
	output reg               o_overflow_flag
);

	localparam DIV_N = 48;
	localparam PROD_W = FILT_W + 2 + GAIN_W + 1;
	localparam RES_W = PROD_W - `AOGC_GAIN_SHIFT;

	// Register file
	reg        [2:0]        option_q;
	reg signed [OFS_W-1:0]  offset_q;
	reg        [GAIN_W-1:0] gain_q;
	reg        [23:0]       data_q;
	reg        [7:0]        iex_q;

	// Bus slave state
	reg        [7:0]        awaddr_q;
	reg        [31:0]       wdata_q;
	reg        [3:0]        wstrb_q;
	reg                     aw_full_q;
	reg                     w_full_q;
	wire                    wr_fire;
	wire                    ar_fire;
	reg        [31:0]       ctrl_rd;
	reg        [31:0]       rd_val;
	reg                     rd_hit;

	// Datapath
	reg                     stage_q;
	reg signed [PROD_W-1:0] prod_q;
	reg                     single_q;
	reg signed [FILT_W+1:0] ofs_scaled;
	reg signed [FILT_W+1:0] diff;
	reg signed [RES_W-1:0]  shifted;
	reg signed [RES_W-1:0]  lim_hi;
	reg signed [RES_W-1:0]  lim_lo;
	reg signed [FILT_W-1:0] ofs_cal;
	reg        [5:0]        res_bits;
	wire                    conv_mode;
	wire                    chop_mode;
	wire                    iex_mode;
	wire                    take_sample;
	wire                    div_done;
	wire       [DIV_N-1:0]  div_quo;
	reg                     div_start_q;
	reg        [DIV_N-1:0]  div_num_q;
	reg        [FILT_W-1:0] div_den_q;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge[8*k +: 8] = nw[8*k +: 8];
				end
			end
		end
	endfunction

	wire       [31:0]       ofs_merged;
	wire       [31:0]       gain_merged;
	assign ofs_merged  = merge({8'h00, offset_q}, wdata_q, wstrb_q);
	assign gain_merged = merge({8'h00, gain_q}, wdata_q, wstrb_q);
	assign wr_fire = aw_full_q && w_full_q && !o_s_axi_bvalid;
	assign ar_fire = i_s_axi_arvalid && o_s_axi_arready;

	assign chop_mode = (o_mode == `AOGC_MODE_SINGLE_CHOP) || (o_mode == `AOGC_MODE_CONT_CHOP)
		|| iex_mode;
	assign iex_mode  = (o_mode == `AOGC_MODE_SINGLE_IEX) || (o_mode == `AOGC_MODE_CONT_IEX);
	assign conv_mode = (o_mode == `AOGC_MODE_CONT) || (o_mode == `AOGC_MODE_SINGLE) || chop_mode;
	assign take_sample = i_filt_valid && (o_mode != `AOGC_MODE_IDLE);

	// Variant-dependent scaling and limits
	always @* begin
		case (option_q[2:1])
			`AOGC_RES_16: begin
				ofs_scaled = $signed(offset_q) <<< `AOGC_OFS_SHIFT_16;
				ofs_cal    = $signed(i_filt_data) >>> `AOGC_OFS_SHIFT_16;
				res_bits   = 6'd16;
			end
			`AOGC_RES_20: begin
				ofs_scaled = $signed(offset_q) <<< `AOGC_OFS_SHIFT_20;
				ofs_cal    = $signed(i_filt_data) >>> `AOGC_OFS_SHIFT_20;
				res_bits   = 6'd20;
			end
			default: begin
				ofs_scaled = $signed(offset_q) <<< `AOGC_OFS_SHIFT_24;
				ofs_cal    = $signed(i_filt_data) >>> `AOGC_OFS_SHIFT_24;
				res_bits   = 6'd24;
			end
		endcase
		// Symmetric-one-short limits of the selected width
		lim_hi = ({{(RES_W-1){1'b0}}, 1'b1} << (res_bits - 6'd1)) - {{(RES_W-1){1'b0}}, 1'b1};
		lim_lo = -(({{(RES_W-1){1'b0}}, 1'b1}) <<< (res_bits - 6'd1));
		// Chopping already cancels offset, so the term is dropped
		if (chop_mode) begin
			diff = $signed({{2{i_filt_data[FILT_W-1]}}, i_filt_data});
		end else begin
			diff = $signed({{2{i_filt_data[FILT_W-1]}}, i_filt_data}) - ofs_scaled;
		end
		// Dropping the low bits is a floor divide on two's complement
		shifted = prod_q[PROD_W-1:`AOGC_GAIN_SHIFT];
	end

	aogc_div #(
		.N (DIV_N),
		.D (FILT_W)
	) u_div (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_start    (div_start_q),
		.i_dividend (div_num_q),
		.i_divisor  (div_den_q),
		.o_done     (div_done),
		.o_quotient (div_quo)
	);

	// Bus write side
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready  <= 1'b1;
			o_s_axi_bvalid  <= 1'b0;
			o_s_axi_bresp   <= `AOGC_RESP_OKAY;
			aw_full_q       <= 1'b0;
			w_full_q        <= 1'b0;
			awaddr_q        <= 8'h00;
			wdata_q         <= 32'h0000_0000;
			wstrb_q         <= 4'h0;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				awaddr_q        <= i_s_axi_awaddr;
				aw_full_q       <= 1'b1;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				wdata_q        <= i_s_axi_wdata;
				wstrb_q        <= i_s_axi_wstrb;
				w_full_q       <= 1'b1;
				o_s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				o_s_axi_bvalid <= 1'b1;
				case (awaddr_q & 8'hFC)
					`AOGC_OFS_CTRL, `AOGC_OFS_OPTION, `AOGC_OFS_OFFSET,
					`AOGC_OFS_GAIN, `AOGC_OFS_DATA, `AOGC_OFS_IEX: begin
						o_s_axi_bresp <= `AOGC_RESP_OKAY;
					end
					default: begin
						o_s_axi_bresp <= `AOGC_RESP_SLVERR;
					end
				endcase
			end
			if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid  <= 1'b0;
				aw_full_q       <= 1'b0;
				w_full_q        <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register read mux
	always @* begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[`AOGC_CTRL_MODE_LSB +: 4]  = o_mode;
		ctrl_rd[`AOGC_CTRL_POS_LSB +: 4]   = o_positive_input_select;
		ctrl_rd[`AOGC_CTRL_NEG_LSB +: 4]   = o_negative_input_select;
		ctrl_rd[`AOGC_CTRL_AMP1_BIT]       = o_first_amp_stage_enable;
		ctrl_rd[`AOGC_CTRL_GAIN_COEFF_WORD_B_LSB +: 3] = o_second_amp_stage_gain;
		ctrl_rd[`AOGC_CTRL_OV_BIT]         = o_overflow_flag;
		ctrl_rd[`AOGC_CTRL_RDYL_BIT]       = o_ready_low_status;
		rd_hit = 1'b1;
		case (i_s_axi_araddr & 8'hFC)
			`AOGC_OFS_CTRL:   rd_val = ctrl_rd;
			`AOGC_OFS_OPTION: rd_val = {29'h0000_0000, option_q};
			`AOGC_OFS_OFFSET: rd_val = {{(32-OFS_W){offset_q[OFS_W-1]}}, offset_q};
			`AOGC_OFS_GAIN:   rd_val = {{(32-GAIN_W){1'b0}}, gain_q};
			`AOGC_OFS_DATA:   rd_val = {{8{data_q[23]}}, data_q};
			`AOGC_OFS_IEX:    rd_val = {24'h00_0000, iex_q};
			default: begin
				rd_val = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_rdata   <= 32'h0000_0000;
			o_s_axi_rresp   <= `AOGC_RESP_OKAY;
		end else if (ar_fire) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid  <= 1'b1;
			o_s_axi_rdata   <= rd_val;
			o_s_axi_rresp   <= rd_hit ? `AOGC_RESP_OKAY : `AOGC_RESP_SLVERR;
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end

	// Control, calibration and correction
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_mode                   <= `AOGC_MODE_IDLE;
			o_positive_input_select  <= 4'h0;
			o_negative_input_select  <= 4'h0;
			o_first_amp_stage_enable <= 1'b0;
			o_second_amp_stage_gain  <= 3'h0;
			o_internal_ref_sel       <= 1'b0;
			o_ready_low_status       <= 1'b0;
			o_overflow_flag          <= 1'b0;
			option_q                 <= `AOGC_RST_OPTION;
			offset_q                 <= `AOGC_RST_OFFSET;
			gain_q                   <= `AOGC_RST_GAIN;
			data_q                   <= 24'h00_0000;
			iex_q                    <= `AOGC_RST_IEX;
			stage_q                  <= 1'b0;
			single_q                 <= 1'b0;
			prod_q                   <= {PROD_W{1'b0}};
			div_start_q              <= 1'b0;
			div_num_q                <= {DIV_N{1'b0}};
			div_den_q                <= {FILT_W{1'b0}};
			o_excitation_source_one_route <= 4'h0;
			o_excitation_source_two_route <= 4'h0;
		end else begin
			div_start_q <= 1'b0;
			stage_q     <= 1'b0;
			o_internal_ref_sel <= option_q[`AOGC_OPT_REFINT_BIT];

			// Stage 1: offset term and full-precision product
			if (take_sample && conv_mode) begin
				prod_q   <= diff * $signed({1'b0, gain_q});
				stage_q  <= 1'b1;
				single_q <= (o_mode == `AOGC_MODE_SINGLE) || (o_mode == `AOGC_MODE_SINGLE_CHOP)
					|| (o_mode == `AOGC_MODE_SINGLE_IEX);
			end

			// Stage 2: range check, clamp by sign, store
			if (stage_q) begin
				if (shifted > lim_hi) begin
					data_q          <= lim_hi[23:0];
					o_overflow_flag <= 1'b1;
				end else if (shifted < lim_lo) begin
					data_q          <= lim_lo[23:0];
					o_overflow_flag <= 1'b1;
				end else begin
					data_q          <= shifted[23:0];
					o_overflow_flag <= 1'b0;
				end
				o_ready_low_status <= 1'b0;
				if (single_q) begin
					o_mode <= `AOGC_MODE_IDLE;
				end
			end

			// Offset calibration stores the scaled-back sample
			if (take_sample && (o_mode == `AOGC_MODE_OFS_CAL)) begin
				offset_q           <= ofs_cal[OFS_W-1:0];
				o_ready_low_status <= 1'b0;
				o_mode             <= `AOGC_MODE_IDLE;
			end

			// Gain calibration: target full scale over measured reference
			if (take_sample && (o_mode == `AOGC_MODE_GAIN_CAL)) begin
				if (i_filt_data[FILT_W-1] || (i_filt_data == {FILT_W{1'b0}})) begin
					// Nonpositive reference reading cannot be inverted; pin to max
					gain_q             <= {GAIN_W{1'b1}};
					o_ready_low_status <= 1'b0;
					o_mode             <= `AOGC_MODE_IDLE;
				end else begin
					div_num_q   <= {{(DIV_N-1){1'b0}}, 1'b1} << (res_bits + 6'd23);
					div_den_q   <= i_filt_data;
					div_start_q <= 1'b1;
					o_ready_low_status <= 1'b1;
				end
			end
			if (div_done) begin
				gain_q <= (|div_quo[DIV_N-1:GAIN_W]) ? {GAIN_W{1'b1}} : div_quo[GAIN_W-1:0];
				o_ready_low_status <= 1'b0;
				o_mode             <= `AOGC_MODE_IDLE;
			end

			// New conversion in progress; outranks a completion in the same cycle
			if (take_sample && conv_mode) begin
				o_ready_low_status <= 1'b1;
			end

			// Excitation routes follow the chopper polarity
			if (iex_mode && i_chop_phase) begin
				o_excitation_source_one_route <= iex_q[`AOGC_IEX_SRC2_LSB +: 4];
				o_excitation_source_two_route <= iex_q[3:0];
			end else begin
				o_excitation_source_one_route <= iex_q[3:0];
				o_excitation_source_two_route <= iex_q[`AOGC_IEX_SRC2_LSB +: 4];
			end

			// Software writes last so a command beats a same-cycle completion
			if (wr_fire) begin
				case (awaddr_q & 8'hFC)
					`AOGC_OFS_CTRL: begin
						o_mode                   <= wstrb_q[0] ? wdata_q[3:0] : o_mode;
						o_positive_input_select  <= wstrb_q[0] ? wdata_q[7:4] :
							o_positive_input_select;
						o_negative_input_select  <= wstrb_q[1] ? wdata_q[11:8] :
							o_negative_input_select;
						o_first_amp_stage_enable <= wstrb_q[1] ? wdata_q[12] :
							o_first_amp_stage_enable;
						o_second_amp_stage_gain  <= wstrb_q[1] ? wdata_q[15:13] :
							o_second_amp_stage_gain;
						if (wstrb_q[0] && (wdata_q[3:0] != `AOGC_MODE_IDLE)) begin
							o_ready_low_status <= 1'b1;
						end
					end
					`AOGC_OFS_OPTION: begin
						if (wstrb_q[0]) begin
							option_q <= wdata_q[2:0];
						end
					end
					`AOGC_OFS_OFFSET: begin
						offset_q <= ofs_merged[OFS_W-1:0];
					end
					`AOGC_OFS_GAIN: begin
						gain_q <= gain_merged[GAIN_W-1:0];
					end
					`AOGC_OFS_IEX: begin
						if (wstrb_q[0]) begin
							iex_q <= wdata_q[7:0];
						end
					end
					default: begin
						iex_q <= iex_q;
					end
				endcase
			end
		end
	end

endmodule // aogc_top

`default_nettype wire

/* File: core/aogc_regs.vh */
// Register map, field positions, reset values and mode codes of the correction block
`ifndef AOGC_REGS_VH
`define AOGC_REGS_VH

`define AOGC_ADDR_W              8
`define AOGC_OFS_CTRL            8'h00
`define AOGC_OFS_OPTION          8'h04
`define AOGC_OFS_OFFSET          8'h08
`define AOGC_OFS_GAIN            8'h0C
`define AOGC_OFS_DATA            8'h10
`define AOGC_OFS_IEX             8'h14

`define AOGC_CTRL_MODE_LSB       0
`define AOGC_CTRL_POS_LSB        4
`define AOGC_CTRL_NEG_LSB        8
`define AOGC_CTRL_AMP1_BIT       12
`define AOGC_CTRL_GAIN_COEFF_WORD_B_LSB      13
`define AOGC_CTRL_OV_BIT         16
`define AOGC_CTRL_RDYL_BIT       17
`define AOGC_OPT_REFINT_BIT      0
`define AOGC_OPT_RES_LSB         1
`define AOGC_IEX_SRC2_LSB        4

`define AOGC_RST_CTRL            32'h0000_0000
`define AOGC_RST_OPTION          3'h4
`define AOGC_RST_OFFSET          24'h00_0000
`define AOGC_RST_GAIN            24'h80_0000
`define AOGC_RST_IEX             8'h00

`define AOGC_MODE_IDLE           4'h0
`define AOGC_MODE_CONT           4'h1
`define AOGC_MODE_SINGLE         4'h2
`define AOGC_MODE_SINGLE_CHOP    4'h4
`define AOGC_MODE_CONT_CHOP      4'h5
`define AOGC_MODE_SINGLE_IEX     4'h6
`define AOGC_MODE_CONT_IEX       4'h7
`define AOGC_MODE_OFS_CAL        4'hC
`define AOGC_MODE_GAIN_CAL       4'hD

`define AOGC_RES_16              2'h0
`define AOGC_RES_20              2'h1
`define AOGC_RES_24              2'h2

`define AOGC_OFS_SHIFT_16        8
`define AOGC_OFS_SHIFT_20        6
`define AOGC_OFS_SHIFT_24        2
`define AOGC_GAIN_SHIFT          24

`define AOGC_RESP_OKAY           2'h0
`define AOGC_RESP_SLVERR         2'h2

`endif

/* File: core/aogc_div.v */
// Restoring serial divider used to derive the gain coefficient
`timescale 1ns/10ps
`default_nettype none

module aogc_div #(
	parameter N = 48,
	parameter D = 26
) (
	input  wire         i_clk,
	input  wire         i_reset,
	input  wire         i_start,
	input  wire [N-1:0] i_dividend,
	input  wire [D-1:0] i_divisor,
	output reg          o_done,
	output reg  [N-1:0] o_quotient
);

	localparam [7:0] N_CNT = N;
	reg  [D:0]   rem_q;
	reg  [N-1:0] quo_q;
	reg  [D-1:0] div_q;
	reg  [7:0]   cnt_q;
	reg          busy_q;
	wire [D:0]   trial;
	wire         take;

	assign trial = {rem_q[D-1:0], quo_q[N-1]};
	assign take  = (trial >= {1'b0, div_q});

	always @(posedge i_clk) begin
		if (i_reset) begin
			rem_q      <= {(D+1){1'b0}};
			quo_q      <= {N{1'b0}};
			div_q      <= {D{1'b0}};
			cnt_q      <= 8'h00;
			busy_q     <= 1'b0;
			o_done     <= 1'b0;
			o_quotient <= {N{1'b0}};
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				rem_q  <= {(D+1){1'b0}};
				quo_q  <= i_dividend;
				div_q  <= i_divisor;
				cnt_q  <= N_CNT;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				// One quotient bit per clock; slow but small
				rem_q <= take ? (trial - {1'b0, div_q}) : trial;
				quo_q <= {quo_q[N-2:0], take};
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					busy_q     <= 1'b0;
					o_done     <= 1'b1;
					o_quotient <= {quo_q[N-2:0], take};
				end
			end
		end
	end

endmodule // aogc_div

`default_nettype wire

/* File: verification/aogc_filter_model.sv */
// Filter-side model that hands conversion samples to the block
`timescale 1ns/10ps
`default_nettype none
module aogc_filter_model (
	input  wire logic        i_clk,
	output var  logic        o_valid,
	output var  logic [25:0] o_data,
	output var  logic        o_phase
);
	initial begin
		o_valid = 1'b0;
		o_data  = 26'h0;
		o_phase = 1'b0;
	end
	// One-cycle result pulse, full scale +-16777216
	task automatic send(input logic [25:0] v);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_data  <= v;
		@(posedge i_clk);
		o_valid <= 1'b0;
		// Scrambled so a stale sample is never reused by luck
		o_data  <= ~v;
	endtask
	// Input polarity swap level seen by excitation chopping
	task automatic phase(input logic p);
		@(posedge i_clk);
		o_phase <= p;
	endtask
endmodule // aogc_filter_model
`default_nettype wire

/* File: verification/aogc_checker.sv */
// Port-level assertions for the correction block
`timescale 1ns/10ps
`default_nettype none
module aogc_checker (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic        o_s_axi_bvalid,
	input wire logic [1:0]  o_s_axi_bresp,
	input wire logic        i_s_axi_bready,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic        o_s_axi_rvalid,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic        i_s_axi_rready,
	input wire logic        i_filt_valid,
	input wire logic        i_chop_phase,
	input wire logic [3:0]  o_mode,
	input wire logic [3:0]  o_excitation_source_one_route,
	input wire logic [3:0]  o_excitation_source_two_route,
	input wire logic        o_ready_low_status
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	logic conv;
	logic excitation_current;
	assign conv = o_mode inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
	assign excitation_current  = o_mode[3:1] == 3'h3;

	chk_rdy_set: assert property (i_filt_valid && conv |=> o_ready_low_status)
		else $error("ready-low not raised after a sample");
	chk_rdy_clear: assert property (i_filt_valid && conv ##1 !i_filt_valid |=> !o_ready_low_status)
		else $error("result not stored two cycles after sample");
	chk_ofs_cal_idle: assert property (i_filt_valid && o_mode == 4'hC |=> o_mode == 4'h0 && !o_ready_low_status)
		else $error("offset calibration did not return to idle");
	chk_gain_cal_idle: assert property (i_filt_valid && o_mode == 4'hD |-> ##[1:60] (o_mode == 4'h0 && !o_ready_low_status))
		else $error("gain calibration did not finish in time");
	chk_iex_swap_back: assert property (excitation_current && i_chop_phase ##1 excitation_current && !i_chop_phase
		|=> o_excitation_source_one_route == $past(o_excitation_source_two_route))
		else $error("excitation routes not swapped with polarity");
	chk_b_latency: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
		else $error("write response late");
	chk_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped before taken");
	chk_r_latency: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read data late");
	chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data changed before taken");
	chk_aw_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("new write accepted while response pending");

	cov_gain_cal: cover property (i_filt_valid && o_mode == 4'hD);
	cov_iex_swap: cover property (excitation_current && $rose(i_chop_phase));
	cov_r_stall: cover property (o_s_axi_rvalid && !i_s_axi_rready);
endmodule // aogc_checker
bind aogc_top aogc_checker aogc_checker_i (.*);
`default_nettype wire

/* File: verification/aogc_top_tb.sv */
// Self-checking bench for the offset and gain correction block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module aogc_top_tb;
	logic        i_clk = 1'b0, i_reset = 1'b1;
	logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rdat, e;
	logic [3:0]  i_s_axi_wstrb = 4'hF;
	logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
	logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, ov;
	logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, resp;
	logic        i_filt_valid, i_chop_phase, o_internal_ref_sel, o_first_amp_stage_enable;
	logic        o_ready_low_status, o_overflow_flag;
	logic [25:0] i_filt_data;
	logic [3:0]  o_mode, o_positive_input_select, o_negative_input_select;
	logic [3:0]  o_excitation_source_one_route, o_excitation_source_two_route;
	logic [2:0]  o_second_amp_stage_gain;
	logic signed [23:0] ofs;
	logic [23:0] g;
	int          n_fail = 0, samples_checked = 0, x;
	logic [3:0]  modes [6] = '{4'h2, 4'h4, 4'h6, 4'h1, 4'h5, 4'h7};
	logic [31:0] rst_tab [6] = '{32'h0, 32'h4, 32'h0, 32'h0080_0000, 32'h0, 32'h0};

	aogc_top aogc_top_i (.*);
	aogc_filter_model aogc_filter_model_i (
		.i_clk  (i_clk),
		.o_valid(i_filt_valid),
		.o_data (i_filt_data),
		.o_phase(i_chop_phase)
	);
	always #10 i_clk = ~i_clk;

	function automatic logic [31:0] expv(input int r, input bit chop, input longint v, input longint o,
		input longint gn, output logic of);
		longint lim, p;
		lim = 64'sd1 <<< (r == 0 ? 15 : r == 1 ? 19 : 23);
		p = ((v - (chop ? 64'sd0 : o * (r == 0 ? 256 : r == 1 ? 64 : 4))) * gn) >>> 24;
		of = (p >= lim) || (p < -lim);
		return 32'(of ? (p < 0 ? -lim : lim - 1) : p);
	endfunction
	// Ready stands with the request, so the answer is taken at its first edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge i_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_wstrb <= s;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
			if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
		end while (!o_s_axi_bvalid);
		i_s_axi_bready <= 1'b0;
		resp = o_s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
		end while (!o_s_axi_rvalid);
		i_s_axi_rready <= 1'b0;
		rdat = o_s_axi_rdata;
		resp = o_s_axi_rresp;
	endtask
	task automatic done_msg(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Generous bound, the tests need under a thousand cycles
	initial begin
		#(50000 * 20);
		n_fail++;
		summarize();
	end

	initial begin
		void'($urandom(70303));
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			rd(8'(k * 4));
			`CHK(rdat, rst_tab[k])
		end
		rd(8'h18);
		`CHK({resp, rdat}, {2'h2, 32'h0})
		wr(8'h18, 32'h0000_0055);
		`CHK(resp, 2'h2)
		wr(8'h10, 32'h0000_1234);
		`CHK(resp, 2'h0)
		rd(8'h10);
		`CHK({resp, rdat}, {2'h0, 32'h0})
		wr(8'h00, 32'h0000_0A00);
		wr(8'h00, 32'h0000_0570, 4'h1);
		rd(8'h00);
		`CHK(rdat[11:0], 12'hA70)
		done_msg("registers");
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 6; k++) begin
				x = k == 0 ? 16777216 : k == 1 ? -16777216 : int'($urandom_range(33554431)) - 16777216;
				ofs = 24'(int'($urandom_range(65535)) - 32768);
				g = 24'($urandom_range(32'h00FFFF << (4 * r)));
				if (k < 2) g = 24'hFFFFFF;
				wr(8'h04, 32'(r) << 1);
				wr(8'h08, 32'(ofs));
				wr(8'h0C, {8'h00, g});
				wr(8'h00, {28'h0, modes[k]});
				aogc_filter_model_i.send(26'(x));
				repeat (3) @(posedge i_clk);
				e = expv(r, modes[k][2], x, ofs, g, ov);
				`CHK(o_overflow_flag, ov)
				rd(8'h10);
				`CHK(rdat, e)
				rd(8'h00);
				`CHK(rdat[17:16], {1'b0, ov})
				`CHK(rdat[3:0], modes[k][0] ? modes[k] : 4'h0)
				wr(8'h00, 32'h0);
			end
		end
		done_msg("conversions");
		wr(8'h14, 32'h0000_0093);
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, k ? 32'h5 : 32'h7);
			aogc_filter_model_i.phase(1'b1);
			repeat (2) @(posedge i_clk);
			`CHK({o_excitation_source_one_route, o_excitation_source_two_route}, k ? 8'h39 : 8'h93)
			aogc_filter_model_i.phase(1'b0);
			repeat (2) @(posedge i_clk);
			`CHK({o_excitation_source_one_route, o_excitation_source_two_route}, 8'h39)
		end
		wr(8'h00, 32'h0);
		done_msg("excitation");
		for (int k = 0; k < 2; k++) begin
			wr(8'h04, 32'h4 | 32'(k));
			wr(8'h00, k ? 32'h0000_098D : 32'h0000_0BAD);
			@(posedge i_clk);
			`CHK({o_positive_input_select, o_negative_input_select, o_internal_ref_sel,
				o_first_amp_stage_enable, o_second_amp_stage_gain}, k ? 13'h1130 : 13'h1560)
			x = 9437184 + 4096 * k;
			aogc_filter_model_i.send(26'(x));
			for (int t = 0; t < 100 && o_mode !== 4'h0; t++) @(posedge i_clk);
			`CHK(o_ready_low_status, 1'b0)
			rd(8'h0C);
			`CHK(rdat[23:0], 24'((64'sd1 <<< 47) / x))
			g = rdat[23:0];
		end
		wr(8'h00, 32'h0000_0BBC);
		x = -12345;
		aogc_filter_model_i.send(26'(x));
		repeat (3) @(posedge i_clk);
		rd(8'h08);
		`CHK(rdat[23:0], 24'(x >>> 2))
		ofs = rdat[23:0];
		wr(8'h00, 32'h2);
		x = 3000000;
		aogc_filter_model_i.send(26'(x));
		repeat (3) @(posedge i_clk);
		rd(8'h10);
		e = expv(2, 1'b0, x, ofs, g, ov);
		`CHK(rdat, e)
		done_msg("calibration");
		summarize();
	end
endmodule // aogc_top_tb
`default_nettype wire
